// *** design/stp_bridge.sv ***
// Spanning-tree bridge core: timers, protocol unit handling, election, ports.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// RULE_01: Blocking ports neither forward nor accept ordinary data.
// RULE_02: Listening ports forward nothing; losing the role sends them back to blocking.
// RULE_03: Learning ports learn source addresses but forward nothing.
// RULE_04: Only forwarding ports pass ordinary data both ways.
// RULE_05: Disabled ports carry management traffic only and always return through blocking.
// RULE_06: No direct blocking to forwarding; each middle state lasts a forward delay.
// RULE_07: Ports wait out propagation and stale units before forwarding.
// RULE_08: Units are recomputed from received contents, sent on topology change.
// RULE_09: Each unit carries root identifier, path cost and sender port identifier.
// RULE_10: With default priorities the lowest MAC address becomes root.
// RULE_11: A smaller bridge priority wins root election.
// RULE_12: The port with the best path to root becomes root port.
// RULE_13: Each segment gets the bridge nearest the root as designated bridge.
// RULE_14: Redundant links stay blocked and reactivate when the primary fails.
// RULE_15: The tree reconfigures itself when elements fail, join or leave.
// RULE_16: Separate trees run over user-chosen groups of ports.
// RULE_17: Only boot-block, block-listen/disable, listen/learn/forward-disable, disable-block moves.
// RULE_18: Bridge identifier is 16-bit priority ahead of 48-bit MAC.
// RULE_19: Hello units go out every two seconds by default.
// RULE_20: Listening and learning each last fifteen seconds by default.
// RULE_21: A three-bit state register per port drives its traffic gates.
module stp_bridge #(
  parameter int unsigned NUM_PORTS = 26,
  parameter int unsigned GRP_W = 2,
  parameter int unsigned TICK_CYC = stp_pkg::TICK_CYC,
  parameter int unsigned HELLO_TICKS = stp_pkg::HELLO_TICKS,
  parameter int unsigned FWD_TICKS = stp_pkg::FWD_TICKS,
  parameter int unsigned MAX_AGE_TICKS = stp_pkg::MAX_AGE_TICKS,
  localparam int unsigned PW = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1,
  localparam int unsigned NG = 1 << GRP_W
) (
  input wire logic ref_clk, // System clock, 25 MHz.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic [stp_pkg::PRIO_W-1:0] bridge_prio, // Bridge priority.
  input wire logic [stp_pkg::MAC_W-1:0] bridge_mac, // Bridge MAC address.
  input wire logic [NUM_PORTS-1:0] port_up, // Link up per port.
  input wire logic [NUM_PORTS-1:0] port_mgmt_dis, // Management disable per port.
  input wire logic [NUM_PORTS-1:0][stp_pkg::PPRIO_W-1:0] port_prio, // Port priority.
  input wire logic [NUM_PORTS-1:0][stp_pkg::PCOST_W-1:0] port_cost, // Port path cost.
  input wire logic [NUM_PORTS-1:0][GRP_W-1:0] port_grp, // Tree group of each port.
  input wire logic rx_bpdu_valid, // Received unit strobe.
  input wire logic [PW-1:0] rx_bpdu_port, // Port the unit arrived on.
  input wire logic [stp_pkg::BID_W-1:0] rx_root_id, // Root the sender believes in.
  input wire logic [stp_pkg::COST_W-1:0] rx_root_cost, // Sender path cost to root.
  input wire logic [stp_pkg::PID_W-1:0] rx_port_id, // Sender port identifier.
  output logic tx_bpdu_valid, // Transmit unit strobe.
  output logic [PW-1:0] tx_bpdu_port, // Port to send the unit on.
  output logic [stp_pkg::BID_W-1:0] tx_root_id, // Root identifier to send.
  output logic [stp_pkg::COST_W-1:0] tx_root_cost, // Our path cost to root.
  output logic [stp_pkg::PID_W-1:0] tx_port_id, // Our port identifier.
  output wire logic [NUM_PORTS-1:0][2:0] port_state, // Port state codes.
  output wire logic [NUM_PORTS-1:0] port_rx_en, // Receive gate per port.
  output wire logic [NUM_PORTS-1:0] port_tx_en, // Forward gate per port.
  output wire logic [NUM_PORTS-1:0] port_learn_en, // Learning gate per port.
  output wire logic [NUM_PORTS-1:0] port_mgmt_only, // Management-only per port.
  output logic [NG-1:0] grp_is_root, // This bridge is root of the group.
  output logic [NG-1:0][PW-1:0] grp_root_port // Root port of the group.
);
  import stp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  if (NUM_PORTS < 1 || NUM_PORTS > 255 || GRP_W < 1) begin : g_bad_size
    $error("NUM_PORTS must lie in 1..255 and GRP_W be at least 1.");
  end
  if (TICK_CYC < 1 || HELLO_TICKS < 1 || HELLO_TICKS >= (1 << TMR_W)
      || MAX_AGE_TICKS < 1 || MAX_AGE_TICKS >= (1 << TMR_W)) begin : g_bad_time
    $error("Timer parameters out of range.");
  end

  localparam int unsigned CW = $clog2(TICK_CYC + 1);

  // Compare two priority vectors; lower wins.
  function automatic logic vec_lt(
    input logic [BID_W-1:0] ra, input logic [COST_W-1:0] ca, input logic [PID_W-1:0] pa,
    input logic [BID_W-1:0] rb, input logic [COST_W-1:0] cb, input logic [PID_W-1:0] pb);
    return {ra, ca, pa} < {rb, cb, pb};
  endfunction

  // Port identifier: priority ahead of the one-based port number.
  function automatic logic [PID_W-1:0] port_ident(input logic [PPRIO_W-1:0] prio,
                                                  input int unsigned idx);
    return {prio, PNUM_W'(idx + 1)};
  endfunction

  logic [NUM_PORTS-1:0] port_ok;
  logic [CW-1:0] cyc_r, cyc_nxt;
  logic tick_r, tick_nxt;
  logic [TMR_W-1:0] hello_r, hello_nxt;
  logic hello_due_r, hello_due_nxt;
  logic [BID_W-1:0] bid_r;
  logic [NUM_PORTS-1:0] vld_r, vld_nxt;
  logic [BID_W-1:0] info_root_r [NUM_PORTS], info_root_nxt [NUM_PORTS];
  logic [COST_W-1:0] info_cost_r [NUM_PORTS], info_cost_nxt [NUM_PORTS];
  logic [PID_W-1:0] info_pid_r [NUM_PORTS], info_pid_nxt [NUM_PORTS];
  logic [TMR_W-1:0] age_r [NUM_PORTS], age_nxt [NUM_PORTS];
  logic [BID_W-1:0] grp_root_r [NG], grp_root_nxt [NG];
  logic [COST_W-1:0] grp_cost_r [NG], grp_cost_nxt [NG];
  logic [NG-1:0] grp_has_rp_r, grp_has_rp_nxt;
  logic [PW-1:0] grp_rp_nxt [NG];
  logic [COST_W-1:0] cand_cost;
  logic [NUM_PORTS-1:0] desig_r, desig_nxt, rootp_r, rootp_nxt;
  logic tc_r, tc_nxt;
  logic [NUM_PORTS-1:0] pend_r, pend_nxt;
  logic tx_vld_nxt;
  logic [PW-1:0] tx_port_nxt;
  logic [BID_W-1:0] tx_root_nxt;
  logic [COST_W-1:0] tx_cost_nxt;
  logic [PID_W-1:0] tx_pid_nxt;
  logic found;

  assign port_ok = port_up & ~port_mgmt_dis;

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond tick and hello interval.
  always_comb begin
    cyc_nxt = cyc_r + 1'b1;
    tick_nxt = 1'b0;
    if (cyc_r == CW'(TICK_CYC - 1)) begin
      cyc_nxt = '0;
      tick_nxt = 1'b1;
    end
    hello_nxt = hello_r;
    hello_due_nxt = 1'b0;
    if (tick_r) begin
      if (hello_r == TMR_W'(HELLO_TICKS - 1)) begin
        hello_nxt = '0;
        hello_due_nxt = 1'b1; // RULE_19
      end else begin
        hello_nxt = hello_r + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stored neighbour information per port, aged out after the maximum age.
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      vld_nxt[p] = vld_r[p];
      info_root_nxt[p] = info_root_r[p];
      info_cost_nxt[p] = info_cost_r[p];
      info_pid_nxt[p] = info_pid_r[p];
      age_nxt[p] = age_r[p];
      if (!port_ok[p]) begin
        vld_nxt[p] = 1'b0; // RULE_14
      end else if (rx_bpdu_valid && rx_bpdu_port == PW'(p)) begin
        vld_nxt[p] = 1'b1; // RULE_09
        info_root_nxt[p] = rx_root_id;
        info_cost_nxt[p] = rx_root_cost;
        info_pid_nxt[p] = rx_port_id;
        age_nxt[p] = '0;
      end else if (tick_r && vld_r[p]) begin
        if (age_r[p] == TMR_W'(MAX_AGE_TICKS)) begin
          vld_nxt[p] = 1'b0; // RULE_15
        end else begin
          age_nxt[p] = age_r[p] + 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Root election and root port choice per port group.
  always_comb begin
    cand_cost = '0;
    for (int g = 0; g < NG; g++) begin
      grp_root_nxt[g] = bid_r; // RULE_10 RULE_11
      grp_cost_nxt[g] = '0;
      grp_rp_nxt[g] = '0;
      grp_has_rp_nxt[g] = 1'b0;
    end
    for (int p = 0; p < NUM_PORTS; p++) begin
      cand_cost = info_cost_r[p] + COST_W'(port_cost[p]);
      if (vld_r[p] && port_ok[p] && vec_lt(info_root_r[p], cand_cost, info_pid_r[p], // RULE_16
          grp_root_nxt[port_grp[p]], grp_cost_nxt[port_grp[p]],
          grp_has_rp_nxt[port_grp[p]] ? info_pid_r[grp_rp_nxt[port_grp[p]]] : '1)) begin
        grp_root_nxt[port_grp[p]] = info_root_r[p]; // RULE_12
        grp_cost_nxt[port_grp[p]] = cand_cost;
        grp_rp_nxt[port_grp[p]] = PW'(p);
        grp_has_rp_nxt[port_grp[p]] = 1'b1;
      end
    end
  end

  // Port roles: root port, or designated when our vector beats the segment's.
  // Roles use this cycle's election, so a port that just heard a better root never
  // drops both roles for a cycle and falls out of forwarding.
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      rootp_nxt[p] = port_ok[p] && grp_has_rp_nxt[port_grp[p]]
                     && grp_rp_nxt[port_grp[p]] == PW'(p); // RULE_12
      desig_nxt[p] = port_ok[p] && !rootp_nxt[p] && (!vld_r[p] // RULE_13
        || vec_lt(grp_root_nxt[port_grp[p]], grp_cost_nxt[port_grp[p]],
                  port_ident(port_prio[p], p), info_root_r[p], info_cost_r[p], info_pid_r[p]));
    end
    // Any role change marks a topology change; duplicates fall to blocking.
    tc_nxt = (desig_nxt != desig_r) || (rootp_nxt != rootp_r); // RULE_14 RULE_15
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outgoing units: one designated port per cycle, lowest index first.
  always_comb begin
    pend_nxt = pend_r;
    found = 1'b0;
    tx_vld_nxt = 1'b0;
    tx_port_nxt = tx_bpdu_port;
    tx_root_nxt = tx_root_id;
    tx_cost_nxt = tx_root_cost;
    tx_pid_nxt = tx_port_id;
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (pend_r[p] && desig_r[p] && !found) begin
        found = 1'b1;
        pend_nxt[p] = 1'b0;
        tx_vld_nxt = 1'b1;
        tx_port_nxt = PW'(p);
        tx_root_nxt = grp_root_r[port_grp[p]]; // RULE_08 RULE_09
        tx_cost_nxt = grp_cost_r[port_grp[p]];
        tx_pid_nxt = port_ident(port_prio[p], p);
      end
    end
    // A new request wins over the bit that is being sent this cycle.
    if (hello_due_r || tc_r) begin
      pend_nxt = pend_nxt | desig_r; // RULE_08 RULE_19
    end
    // A port that lost its designated role sends nothing more.
    pend_nxt = pend_nxt & port_ok & desig_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register all state.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cyc_r <= '0;
      tick_r <= 1'b0;
      hello_r <= '0;
      hello_due_r <= 1'b0;
      bid_r <= '0;
      vld_r <= '0;
      desig_r <= '0;
      rootp_r <= '0;
      tc_r <= 1'b0;
      pend_r <= '0;
      grp_has_rp_r <= '0;
      grp_is_root <= '0;
      tx_bpdu_valid <= 1'b0;
      tx_bpdu_port <= '0;
      tx_root_id <= '0;
      tx_root_cost <= '0;
      tx_port_id <= '0;
      for (int p = 0; p < NUM_PORTS; p++) begin
        info_root_r[p] <= '0;
        info_cost_r[p] <= '0;
        info_pid_r[p] <= '0;
        age_r[p] <= '0;
      end
      for (int g = 0; g < NG; g++) begin
        grp_root_r[g] <= '0;
        grp_cost_r[g] <= '0;
        grp_root_port[g] <= '0;
      end
    end else begin
      cyc_r <= cyc_nxt;
      tick_r <= tick_nxt;
      hello_r <= hello_nxt;
      hello_due_r <= hello_due_nxt;
      bid_r <= {bridge_prio, bridge_mac}; // RULE_18
      vld_r <= vld_nxt;
      desig_r <= desig_nxt;
      rootp_r <= rootp_nxt;
      tc_r <= tc_nxt;
      pend_r <= pend_nxt;
      grp_has_rp_r <= grp_has_rp_nxt;
      grp_is_root <= ~grp_has_rp_nxt;
      tx_bpdu_valid <= tx_vld_nxt;
      tx_bpdu_port <= tx_port_nxt;
      tx_root_id <= tx_root_nxt;
      tx_root_cost <= tx_cost_nxt;
      tx_port_id <= tx_pid_nxt;
      info_root_r <= info_root_nxt;
      info_cost_r <= info_cost_nxt;
      info_pid_r <= info_pid_nxt;
      age_r <= age_nxt;
      grp_root_r <= grp_root_nxt;
      grp_cost_r <= grp_cost_nxt;
      for (int g = 0; g < NG; g++) begin
        grp_root_port[g] <= grp_rp_nxt[g];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One state machine per port; only root and designated ports advance.
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    stp_port_fsm #(
      .FWD_TICKS(FWD_TICKS)
    ) u_fsm (
      .ref_clk(ref_clk),
      .srst(srst),
      .tick(tick_r),
      .port_up(port_ok[p]),
      .want_fwd(desig_r[p] | rootp_r[p]), // RULE_14
      .state_r(port_state[p]), // RULE_21
      .rx_en_r(port_rx_en[p]),
      .tx_en_r(port_tx_en[p]),
      .learn_en_r(port_learn_en[p]),
      .mgmt_only_r(port_mgmt_only[p])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  chk_self_root: assert property (!grp_has_rp_r[0] |-> grp_root_r[0] == $past(bid_r)) // RULE_10
    else $error("Group without root port does not claim root.");
  chk_tx_ident: assert property (tx_bpdu_valid |-> // RULE_09
    tx_port_id[PNUM_W-1:0] == PNUM_W'(tx_bpdu_port) + 8'h01) else $error("Bad sender port id.");
  chk_tx_desig: assert property (tx_bpdu_valid |-> $past(pend_r) != '0) // RULE_08
    else $error("Unit sent without a pending request.");
endmodule
`default_nettype wire

// *** design/stp_pkg.sv ***
// Shared constants and types for the spanning-tree port control block.
`default_nettype none
package stp_pkg;
  // Clock rate and the millisecond tick derived from it.
  localparam int unsigned CLK_KHZ = 25_000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYC = CLK_KHZ * TICK_MS;
  localparam int unsigned MS_PER_S = 1000;
  // Protocol timers in seconds and in ticks.
  localparam int unsigned HELLO_S = 2;
  localparam int unsigned FWD_DELAY_S = 15;
  localparam int unsigned MAX_AGE_S = 20;
  localparam int unsigned HELLO_TICKS = HELLO_S * MS_PER_S / TICK_MS;
  localparam int unsigned FWD_TICKS = FWD_DELAY_S * MS_PER_S / TICK_MS;
  localparam int unsigned MAX_AGE_TICKS = MAX_AGE_S * MS_PER_S / TICK_MS;
  // Field widths of identifiers, costs and timers.
  localparam int unsigned PRIO_W = 16;
  localparam int unsigned MAC_W = 48;
  localparam int unsigned BID_W = PRIO_W + MAC_W;
  localparam int unsigned COST_W = 32;
  localparam int unsigned PCOST_W = 16;
  localparam int unsigned PPRIO_W = 8;
  localparam int unsigned PNUM_W = 8;
  localparam int unsigned PID_W = PPRIO_W + PNUM_W;
  localparam int unsigned TMR_W = 16;
  // Port states.
  typedef enum logic [2:0] {
    ST_BLOCK,
    ST_LISTEN,
    ST_LEARN,
    ST_FWD,
    ST_DISABLED
  } stp_state_t;
endpackage
`default_nettype wire

// *** design/stp_port_fsm.sv ***
// Per-port five-state machine with forward delay timing and traffic gates.
`timescale 1ns/1ns
`default_nettype none
module stp_port_fsm #(
  parameter int unsigned FWD_TICKS = stp_pkg::FWD_TICKS
) (
  input wire logic ref_clk, // System clock.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic tick, // One-cycle millisecond tick.
  input wire logic port_up, // Port has link and is not disabled by management.
  input wire logic want_fwd, // Port holds a root or designated role.
  output stp_pkg::stp_state_t state_r, // Current port state.
  output logic rx_en_r, // Ordinary data may be received.
  output logic tx_en_r, // Ordinary data may be forwarded out.
  output logic learn_en_r, // Source addresses may be learned.
  output logic mgmt_only_r // Only management traffic is handled.
);
  import stp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  if (FWD_TICKS < 1 || FWD_TICKS >= (1 << TMR_W) - 1) begin : g_bad_fwd
    $error("FWD_TICKS does not fit the state timer.");
  end

  stp_state_t state_nxt;
  logic [TMR_W-1:0] tmr_r;
  logic [TMR_W-1:0] tmr_nxt;
  logic rx_en_nxt;
  logic tx_en_nxt;
  logic learn_en_nxt;
  logic mgmt_only_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Next state; listening and learning each last one forward delay.
  always_comb begin
    state_nxt = state_r;
    tmr_nxt = tmr_r;
    unique case (state_r)
      ST_BLOCK: begin
        if (!port_up) begin
          state_nxt = ST_DISABLED; // RULE_17
        end else if (want_fwd) begin
          state_nxt = ST_LISTEN; // RULE_06
          tmr_nxt = '0;
        end
      end
      ST_LISTEN, ST_LEARN: begin
        if (!port_up || !want_fwd) begin
          state_nxt = ST_DISABLED; // RULE_02
        end else if (tick) begin
          if (tmr_r == TMR_W'(FWD_TICKS)) begin
            state_nxt = (state_r == ST_LISTEN) ? ST_LEARN : ST_FWD; // RULE_20
            tmr_nxt = '0;
          end else begin
            tmr_nxt = tmr_r + 1'b1; // RULE_07
          end
        end
      end
      ST_FWD: begin
        if (!port_up || !want_fwd) begin
          state_nxt = ST_DISABLED; // RULE_17
        end
      end
      ST_DISABLED: begin
        if (port_up) begin
          state_nxt = ST_BLOCK; // RULE_05
        end
      end
      default: state_nxt = ST_BLOCK;
    endcase
    // Gates decode the next state and are registered with it, so they change with the state register.
    rx_en_nxt = (state_nxt == ST_FWD); // RULE_01 RULE_04 RULE_21
    tx_en_nxt = (state_nxt == ST_FWD); // RULE_04 RULE_21
    learn_en_nxt = (state_nxt == ST_LEARN) || (state_nxt == ST_FWD); // RULE_03
    mgmt_only_nxt = (state_nxt == ST_DISABLED); // RULE_05
  end

  // State and gate registers; boot lands in blocking.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_r <= ST_BLOCK; // RULE_17
      tmr_r <= '0;
      rx_en_r <= 1'b0;
      tx_en_r <= 1'b0;
      learn_en_r <= 1'b0;
      mgmt_only_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      tmr_r <= tmr_nxt;
      rx_en_r <= rx_en_nxt;
      tx_en_r <= tx_en_nxt;
      learn_en_r <= learn_en_nxt;
      mgmt_only_r <= mgmt_only_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  chk_block_no_skip: assert property (state_r == ST_BLOCK |=> // RULE_06
    state_r inside {ST_BLOCK, ST_LISTEN, ST_DISABLED}) else $error("Blocking skipped ahead.");
  chk_fwd_from_learn: assert property (($changed(state_r) && state_r == ST_FWD) // RULE_17
    |-> $past(state_r) == ST_LEARN) else $error("Forwarding not entered from learning.");
  chk_disabled_exit: assert property (state_r == ST_DISABLED |=> // RULE_05
    state_r inside {ST_DISABLED, ST_BLOCK}) else $error("Disabled left not to blocking.");
  chk_data_gates: assert property ((rx_en_r || tx_en_r) |-> // RULE_01
    state_r == ST_FWD) else $error("Data passed outside forwarding.");
  chk_fwd_opens: assert property (state_r == ST_FWD |-> rx_en_r && tx_en_r) // RULE_04
    else $error("Forwarding port does not pass data.");
  chk_learn_gate: assert property (learn_en_r == (state_r inside {ST_LEARN, ST_FWD})) // RULE_03
    else $error("Learning gate disagrees with state.");
  chk_mgmt_gate: assert property (mgmt_only_r == (state_r == ST_DISABLED)) // RULE_05
    else $error("Management-only flag disagrees with state.");
  chk_delay_full: assert property (($changed(state_r) && state_r == ST_LEARN) |-> // RULE_20
    $past(tmr_r) == TMR_W'(FWD_TICKS) && $past(tick)) else $error("Listening cut short.");
  chk_role_loss: assert property ((state_r inside {ST_LISTEN, ST_LEARN} && port_up // RULE_02
    && !want_fwd) |=> (state_r == ST_DISABLED) and (port_up |=> state_r == ST_BLOCK))
    else $error("Lost role did not return to blocking.");
endmodule
`default_nettype wire

// *** dv/stp_bridge_test.sv ***
// Self-checking testbench of the spanning-tree bridge core.
`timescale 1ns/1ns
`default_nettype none
module stp_bridge_test;
  import stp_pkg::*;
  localparam int unsigned NP = 4;
  localparam int unsigned TC = 4;
  localparam int unsigned FT = 5;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [15:0] bridge_prio = 16'h8000;
  logic [47:0] bridge_mac = 48'h0200_0000_0010;
  logic [NP-1:0] port_up = 4'hf;
  logic [NP-1:0] port_mgmt_dis = 4'h0;
  logic [NP-1:0] port_grp = 4'h8;
  logic nb_send = 1'b0;
  logic [1:0] nb_port = 2'h1;
  logic [63:0] nb_root = 64'h1000_0200_0000_0099;
  logic [31:0] nb_cost = 32'h0000_0004;
  logic [15:0] nb_pid = 16'h8001;
  logic rx_v, tx_v;
  logic [1:0] rx_port, tx_port;
  logic [63:0] rx_root, tx_root;
  logic [31:0] rx_cost, tx_cost;
  logic [15:0] rx_pid, tx_pid;
  logic [NP-1:0][2:0] st;
  logic [NP-1:0] rxe, txe, lre, mgo;
  logic [1:0] gir;
  logic [1:0][1:0] grp;
  int n_mismatch = 0;
  int n_checks = 0;
  int n;
  ////////////////////////////////////////////////////////////////////////
  // Clock, the neighbour and the bridge.
  always #20 ref_clk = ~ref_clk;
  stp_nbr #(.PW(2)) nbr (.ref_clk(ref_clk), .send(nb_send), .port_sel(nb_port),
    .root_id(nb_root), .root_cost(nb_cost), .port_id(nb_pid), .rx_bpdu_valid(rx_v),
    .rx_bpdu_port(rx_port), .rx_root_id(rx_root), .rx_root_cost(rx_cost), .rx_port_id(rx_pid));
  stp_bridge #(.NUM_PORTS(NP), .GRP_W(1), .TICK_CYC(TC), .HELLO_TICKS(20), .FWD_TICKS(FT),
    .MAX_AGE_TICKS(30)) dut (.ref_clk(ref_clk), .srst(srst), .bridge_prio(bridge_prio),
    .bridge_mac(bridge_mac), .port_up(port_up), .port_mgmt_dis(port_mgmt_dis),
    .port_prio({4{8'h80}}), .port_cost({4{16'h0013}}), .port_grp(port_grp),
    .rx_bpdu_valid(rx_v), .rx_bpdu_port(rx_port), .rx_root_id(rx_root),
    .rx_root_cost(rx_cost), .rx_port_id(rx_pid), .tx_bpdu_valid(tx_v), .tx_bpdu_port(tx_port),
    .tx_root_id(tx_root), .tx_root_cost(tx_cost), .tx_port_id(tx_pid), .port_state(st),
    .port_rx_en(rxe), .port_tx_en(txe), .port_learn_en(lre), .port_mgmt_only(mgo),
    .grp_is_root(gir), .grp_root_port(grp));
  ////////////////////////////////////////////////////////////////////////
  // Shared compare, waits and the verdict.
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic wait_st(input int p, input logic [2:0] s, input int lim);
    n = 0;
    while (st[p] !== s && n < lim) begin
      step();
      n++;
    end
  endtask
  task automatic wait_tx(input int lim);
    n = 0;
    while (tx_v !== 1'b1 && n < lim) begin
      step();
      n++;
    end
  endtask
  task automatic final_report();
    if (n_mismatch == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_reset();
    check(st, 12'h000);
    check({rxe, txe, lre, mgo}, 16'h0000);
  endtask
  task automatic t_climb();
    wait_st(0, 3'h1, 20);
    check(st[0], 3'h1);
    check({rxe[0], txe[0], lre[0]}, 3'h0);
    wait_st(0, 3'h2, 40);
    check(n >= FT * TC && n <= (FT + 2) * TC, 1);
    check({rxe[0], txe[0], lre[0]}, 3'h1);
    wait_st(0, 3'h3, 40);
    check(n >= FT * TC && n <= (FT + 2) * TC, 1);
    check({rxe[0], txe[0], lre[0], mgo[0]}, 4'he);
    check(gir[0], 1'b1);
  endtask
  task automatic t_hello();
    step();
    wait_tx(120);
    check(tx_root, {bridge_prio, bridge_mac});
    check(tx_cost, 32'h0000_0000);
    check(tx_port, 2'h0);
    check(tx_pid, 16'h8001);
    repeat (NP) step();
    wait_tx(120);
    check(n >= 72 && n <= 80, 1);
  endtask
  task automatic t_better_root();
    @(posedge ref_clk);
    nb_send <= 1'b1;
    @(posedge ref_clk);
    nb_port <= 2'h2;
    nb_pid <= 16'h8002;
    @(posedge ref_clk);
    nb_send <= 1'b0;
    repeat (4) step();
    check(gir, 2'h2);
    check(grp[0], 2'h1);
    wait_tx(120);
    check(tx_root, nb_root);
    check(tx_cost, 32'h0000_0017);
    check({st[1], st[2]}, 6'h18);
    step();
    check({tx_v, tx_port}, 3'h7);
    check(tx_root, {bridge_prio, bridge_mac});
  endtask
  task automatic t_link_down();
    @(posedge ref_clk);
    port_up <= 4'hd;
    wait_st(1, 3'h4, 6);
    check({st[1], mgo[1], rxe[1], txe[1]}, 6'h24);
    repeat (6) step();
    check(gir[0], 1'b0);
    check(grp[0], 2'h2);
    check(st[2], 3'h1);
    @(posedge ref_clk);
    port_up <= 4'hf;
    wait_st(1, 3'h0, 6);
    check(st[1], 3'h0);
    wait_st(1, 3'h1, 10);
    check(st[1], 3'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog.
  initial begin
    repeat (5) step();
    t_reset();
    @(posedge ref_clk);
    srst <= 1'b0;
    t_climb();
    t_hello();
    t_better_root();
    t_link_down();
    final_report();
  end
  initial begin
    repeat (3000) @(posedge ref_clk);
    n_mismatch++;
    final_report();
  end
endmodule
`default_nettype wire

// *** dv/stp_nbr.sv ***
// Neighbouring bridge model that sends spanning-tree units into the bridge.
`timescale 1ns/1ns
`default_nettype none
module stp_nbr #(
  parameter int unsigned PW = 2
) (
  input wire logic ref_clk, // System clock.
  input wire logic send, // Send one unit at the next edge.
  input wire logic [PW-1:0] port_sel, // Port the unit goes to.
  input wire logic [stp_pkg::BID_W-1:0] root_id, // Root we claim.
  input wire logic [stp_pkg::COST_W-1:0] root_cost, // Our cost to that root.
  input wire logic [stp_pkg::PID_W-1:0] port_id, // Our sending port.
  output logic rx_bpdu_valid, // Unit strobe.
  output logic [PW-1:0] rx_bpdu_port, // Arrival port.
  output logic [stp_pkg::BID_W-1:0] rx_root_id, // Root field.
  output logic [stp_pkg::COST_W-1:0] rx_root_cost, // Cost field.
  output logic [stp_pkg::PID_W-1:0] rx_port_id // Port field.
);
  // A unit carries all three fields in one beat; outside it the fields toggle.
  always_ff @(posedge ref_clk) begin
    rx_bpdu_valid <= send;
    if (send) begin
      rx_bpdu_port <= port_sel;
      rx_root_id <= root_id;
      rx_root_cost <= root_cost;
      rx_port_id <= port_id;
    end else begin
      rx_bpdu_port <= ~rx_bpdu_port;
      rx_root_id <= ~rx_root_id;
      rx_root_cost <= ~rx_root_cost;
      rx_port_id <= ~rx_port_id;
    end
  end
endmodule
`default_nettype wire
